// *** design/dif_top.sv ***
// Multi-function digital input command logic of a motor drive
// Contract
// - Jog forward or reverse runs at jog frequency, above every other reference.
// - Jog held over 500 ms stops the motor by the configured stop mode.
// - UP/DOWN act only when the main frequency source equals 2.
// - UP alone accelerates, DOWN alone decelerates, neither holds frequency.
// - Config error when only one of UP/DOWN assigned or both active; the code flags it only while the main frequency source is 2.
// - UP/DOWN ramps use the selected accel/decel pair, one or two.
// - Forward run plus momentary UP/DOWN pulse ramps up to lower limit.
// - UP/DOWN output frequency clamps between lower and upper limits.
// - Hold input freezes any ramp at the present frequency.
// - With retention set, reference captured at hold is stored across power-down.
// - Hold release resumes ramping and discards the stored reference.
// - Run-source switch selects the alternative run command source.
// - Local/remote input overrides both run and frequency source switches.
// - Frequency-source switch selects the alternative frequency source.
// - PID enabled ignores frequency switch and routes main frequency to PID.
// - Emergency stop ramps to zero with the emergency deceleration time.
// - Output block turns output off and reports the terminal number 1 to 8.
// - Block released in run or accel resumes, from reference or 0 Hz.
// - Block released after being applied in decel stays stopped.
// - Fault reset clears a trip only with the run command removed.
// - External fault turns output off to coast and reports its terminal.
// - 3-wire function on terminals 3-6 makes terminal 1 run, terminal 2 stop.
//
// Added by the designer: the register offsets and the address-and-strobe port.
module dif_top #(
	parameter int TICK_CYC = dif_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Input terminals, 1 = conducting
	input wire logic [dif_pkg::NTERM-1:0] term_i,
	// Register port
	input wire logic [dif_pkg::ADDR_W-1:0] addr_i,
	input wire logic [dif_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [dif_pkg::DATA_W-1:0] rdata_o,
	// Drive command outputs
	output logic [dif_pkg::FW-1:0] freq_o,
	output logic out_en_o,
	output logic reverse_o,
	output logic [dif_pkg::SRC_W-1:0] run_src_o,
	output logic [dif_pkg::SRC_W-1:0] freq_src_o,
	// Status and messages
	output logic terminal_config_error_o,
	output logic trip_o,
	output logic [3:0] output_block_message_o,
	output logic [3:0] external_fault_message_o,
	// Retained hold reference to nonvolatile store
	output logic nv_store_o,
	output logic [dif_pkg::FW-1:0] nv_data_o
);
	import dif_pkg::*;

	function automatic logic [NTERM-1:0] assigned(input logic [NTERM*CODE_W-1:0] fs,
		input logic [CODE_W-1:0] code);
		logic [NTERM-1:0] m;
		m = '0;
		for (int i = 0; i < NTERM; i++)
			m[i] = (fs[i*CODE_W +: CODE_W] == code);
		return m;
	endfunction

	function automatic logic [3:0] first_num(input logic [NTERM-1:0] m);
		logic [3:0] n;
		n = 4'h0;
		for (int i = NTERM - 1; i >= 0; i--)
			if (m[i])
				n = 4'(i + 1);
		return n;
	endfunction

	logic rst_s1_r, rst_n;
	logic [NTERM-1:0] term_s1_r, din_r;
	logic [NTERM*CODE_W-1:0] fsel_r;
	logic [SRC_W-1:0] main_fsrc_r, main_rsrc_r, alt_rsrc_r, alt_fsrc_r;
	logic [FW-1:0] upper_r, lower_r, jog_freq_r, freq_ref_r;
	logic [FW-1:0] acc1_r, dec1_r, acc2_r, dec2_r, estop_dec_r;
	logic [4:0] ctrl_r;
	logic [14:0] div_r;
	logic tick_r;
	logic [9:0] jog_cnt_r;
	dif_state_t state_r, state_nxt;
	logic wire3_run_r, ud_min_r, hold_d_r, block_d_r, blk_decel_r;
	logic [FW-1:0] held_r, ramp_freq;
	// Decoded terminal functions
	logic fwd, rev, jog, up, dn, hold, estop, block, freset, extf, run_cmd;
	logic ud_on, ud_only_one, jog_over, set2, load, resume;
	logic [FW-1:0] target, load_val, acc_per, dec_per;

	// Reset release through two flops
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// Terminal synchroniser
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			term_s1_r <= '0;
			din_r <= '0;
		end else begin
			term_s1_r <= term_i;
			din_r <= term_s1_r;
		end
	end

	// Millisecond tick
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (div_r == 15'(TICK_CYC - 1));
			div_r <= (div_r == 15'(TICK_CYC - 1)) ? '0 : div_r + 15'h0001;
		end
	end

	// Register writes
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fsel_r <= {NTERM{FSEL_RST}};
			main_fsrc_r <= SRC_RST;
			main_rsrc_r <= SRC_RST;
			alt_rsrc_r <= SRC_RST;
			alt_fsrc_r <= SRC_RST;
			upper_r <= UPPER_RST;
			lower_r <= LOWER_RST;
			jog_freq_r <= JOG_RST;
			freq_ref_r <= '0;
			acc1_r <= TIME_RST;
			dec1_r <= TIME_RST;
			acc2_r <= TIME_RST;
			dec2_r <= TIME_RST;
			estop_dec_r <= TIME_RST;
			ctrl_r <= '0;
		end else if (wr_i) begin
			if (addr_i < REG_FSEL_BASE + 8'(NTERM))
				fsel_r[addr_i[2:0]*CODE_W +: CODE_W] <= wdata_i[CODE_W-1:0];
			unique case (addr_i)
				REG_MAIN_FSRC: main_fsrc_r <= wdata_i[SRC_W-1:0];
				REG_UPPER: upper_r <= wdata_i;
				REG_LOWER: lower_r <= wdata_i;
				REG_JOG_FREQ: jog_freq_r <= wdata_i;
				REG_ACC1: acc1_r <= wdata_i;
				REG_DEC1: dec1_r <= wdata_i;
				REG_ACC2: acc2_r <= wdata_i;
				REG_DEC2: dec2_r <= wdata_i;
				REG_ESTOP_DEC: estop_dec_r <= wdata_i;
				REG_CTRL: ctrl_r <= wdata_i[4:0];
				REG_MAIN_RSRC: main_rsrc_r <= wdata_i[SRC_W-1:0];
				REG_ALT_RSRC: alt_rsrc_r <= wdata_i[SRC_W-1:0];
				REG_ALT_FSRC: alt_fsrc_r <= wdata_i[SRC_W-1:0];
				REG_FREQ_REF: freq_ref_r <= wdata_i;
				default: ;
			endcase
		end
	end

	// Register reads, unmapped reads return zero
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			rdata_o <= '0;
			if (addr_i < REG_FSEL_BASE + 8'(NTERM))
				rdata_o <= 16'(fsel_r[addr_i[2:0]*CODE_W +: CODE_W]);
			unique case (addr_i)
				REG_MAIN_FSRC: rdata_o <= 16'(main_fsrc_r);
				REG_UPPER: rdata_o <= upper_r;
				REG_LOWER: rdata_o <= lower_r;
				REG_JOG_FREQ: rdata_o <= jog_freq_r;
				REG_ACC1: rdata_o <= acc1_r;
				REG_DEC1: rdata_o <= dec1_r;
				REG_ACC2: rdata_o <= acc2_r;
				REG_DEC2: rdata_o <= dec2_r;
				REG_ESTOP_DEC: rdata_o <= estop_dec_r;
				REG_CTRL: rdata_o <= 16'(ctrl_r);
				REG_MAIN_RSRC: rdata_o <= 16'(main_rsrc_r);
				REG_ALT_RSRC: rdata_o <= 16'(alt_rsrc_r);
				REG_ALT_FSRC: rdata_o <= 16'(alt_fsrc_r);
				REG_FREQ_REF: rdata_o <= freq_ref_r;
				REG_STATUS: rdata_o <= {7'h00, state_r, hold, block,
					terminal_config_error_o, trip_o, out_en_o};
				REG_OUT_FREQ: rdata_o <= ramp_freq;
				REG_MSG: rdata_o <= {8'h00, external_fault_message_o, output_block_message_o};
				REG_HELD: rdata_o <= held_r;
				default: ;
			endcase
		end
	end

	// Terminal function decode
	always_comb begin
		logic wire3;
		wire3 = |(assigned(fsel_r, FN_WIRE3) & 8'h3c);
		if (wire3) begin
			fwd = wire3_run_r & ~(|(assigned(fsel_r, FN_WIRE3) & din_r));
			rev = wire3_run_r & (|(assigned(fsel_r, FN_WIRE3) & din_r));
		end else begin
			fwd = |(assigned(fsel_r, FN_FWD) & din_r);
			rev = |(assigned(fsel_r, FN_REV) & din_r);
		end
		jog = |((assigned(fsel_r, FN_JOG_FWD) | assigned(fsel_r, FN_JOG_REV)) & din_r);
		up = |(assigned(fsel_r, FN_UP) & din_r);
		dn = |(assigned(fsel_r, FN_DOWN) & din_r);
		hold = |(assigned(fsel_r, FN_HOLD) & din_r);
		estop = |(assigned(fsel_r, FN_ESTOP) & din_r);
		block = |(assigned(fsel_r, FN_BLOCK) & din_r);
		freset = |(assigned(fsel_r, FN_FRESET) & din_r);
		extf = |(assigned(fsel_r, FN_EXT_FAULT) & din_r);
		set2 = ctrl_r[CTRL_SET2] | (|(assigned(fsel_r, FN_ACC_SET2) & din_r));
		run_cmd = fwd | rev | jog;
		ud_only_one = (|assigned(fsel_r, FN_UP)) != (|assigned(fsel_r, FN_DOWN));
		// Both active stays in UP/DOWN mode and falls through to hold
		ud_on = (main_fsrc_r == FSRC_UPDOWN) && !ud_only_one;
		jog_over = jog && (jog_cnt_r > JOG_LIMIT_TICKS);
	end

	// 3-wire run latch: terminal 1 run, terminal 2 low stops
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n)
			wire3_run_r <= 1'b0;
		else if (!din_r[1])
			wire3_run_r <= 1'b0;
		else if (din_r[0])
			wire3_run_r <= 1'b1;
	end

	// Jog duration counter in milliseconds
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n)
			jog_cnt_r <= '0;
		else if (!jog)
			jog_cnt_r <= '0;
		else if (tick_r && jog_cnt_r <= JOG_LIMIT_TICKS)
			jog_cnt_r <= jog_cnt_r + 10'h001;
	end

	// Ramp target and rates
	always_comb begin
		target = freq_ref_r;
		acc_per = set2 ? acc2_r : acc1_r;
		dec_per = set2 ? dec2_r : dec1_r;
		if (jog) begin
			target = jog_freq_r;
		end else if (ud_on) begin
			if (up && !dn)
				target = upper_r;
			else if (dn && !up)
				target = lower_r;
			else if (ud_min_r)
				target = lower_r;
			else
				target = ramp_freq;
			if (target > upper_r)
				target = upper_r;
			if (target < lower_r)
				target = lower_r;
		end
		if (estop) begin
			target = '0;
			dec_per = estop_dec_r;
		end
		if (state_r != ST_RUN || jog_over)
			target = '0;
	end

	// Momentary UP/DOWN pulse under forward run
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n)
			ud_min_r <= 1'b0;
		else if (!ud_on || !fwd || ramp_freq >= lower_r)
			ud_min_r <= 1'b0;
		else if (up || dn)
			ud_min_r <= 1'b1;
	end

	// Drive sequence
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: if (run_cmd && !trip_o && !estop && !block && !jog_over)
				state_nxt = ST_RUN;
			ST_RUN: if (!run_cmd || estop || jog_over)
				state_nxt = ST_DECEL;
			ST_DECEL: if (ramp_freq == '0)
				state_nxt = ST_IDLE;
			ST_LOCKED: if (!block && !run_cmd)
				state_nxt = ST_IDLE;
		endcase
		if (jog_over && ctrl_r[CTRL_COAST] && state_r != ST_LOCKED)
			state_nxt = ST_IDLE;
		if (block && state_r == ST_DECEL)
			state_nxt = ST_LOCKED;
		if (trip_o || extf)
			state_nxt = ST_IDLE;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Block edge tracking
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			block_d_r <= 1'b0;
			blk_decel_r <= 1'b0;
		end else begin
			block_d_r <= block;
			if (block && !block_d_r)
				blk_decel_r <= (state_r == ST_DECEL);
		end
	end

	assign resume = block_d_r && !block && !blk_decel_r && state_r == ST_RUN;
	assign load = (block && !block_d_r) || resume || state_nxt == ST_IDLE && state_r != ST_DECEL;
	assign load_val = (resume && ctrl_r[CTRL_SSRCH]) ? target : '0;

	dif_ramp u_ramp (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.tick_i(tick_r),
		.run_i(!hold && !block),
		.load_i(load),
		.load_val_i(load_val),
		.target_i(target),
		.acc_per_i(acc_per),
		.dec_per_i(dec_per),
		.freq_o(ramp_freq)
	);

	// Hold reference capture and release
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hold_d_r <= 1'b0;
			held_r <= '0;
			nv_store_o <= 1'b0;
			nv_data_o <= '0;
		end else begin
			hold_d_r <= hold;
			nv_store_o <= 1'b0;
			if (hold && !hold_d_r) begin
				held_r <= target;
				if (ctrl_r[CTRL_RETAIN]) begin
					nv_store_o <= 1'b1;
					nv_data_o <= target;
				end
			end else if (!hold && hold_d_r) begin
				held_r <= '0;
				if (ctrl_r[CTRL_RETAIN]) begin
					nv_store_o <= 1'b1;
					nv_data_o <= '0;
				end
			end
		end
	end

	// Trip: set wins over reset
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			trip_o <= 1'b0;
			external_fault_message_o <= 4'h0;
		end else if (extf) begin
			trip_o <= 1'b1;
			external_fault_message_o <= first_num(assigned(fsel_r, FN_EXT_FAULT) & din_r);
		end else if (freset && !run_cmd) begin
			trip_o <= 1'b0;
			external_fault_message_o <= 4'h0;
		end
	end

	// Source selection and drive outputs
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			run_src_o <= SRC_RST;
			freq_src_o <= SRC_RST;
			freq_o <= '0;
			out_en_o <= 1'b0;
			reverse_o <= 1'b0;
			terminal_config_error_o <= 1'b0;
			output_block_message_o <= 4'h0;
		end else begin
			if (|(assigned(fsel_r, FN_LOC_REM) & din_r)) begin
				run_src_o <= SRC_LOCAL;
				freq_src_o <= SRC_LOCAL;
			end else begin
				run_src_o <= (|(assigned(fsel_r, FN_RUN_ALT) & din_r)) ? alt_rsrc_r : main_rsrc_r;
				if (ctrl_r[CTRL_PID])
					freq_src_o <= SRC_PID;
				else
					freq_src_o <= (|(assigned(fsel_r, FN_FREQ_ALT) & din_r)) ? alt_fsrc_r : main_fsrc_r;
			end
			freq_o <= block ? '0 : ramp_freq;
			out_en_o <= !block && !trip_o && !extf && state_r != ST_IDLE && state_r != ST_LOCKED;
			if (state_r == ST_IDLE)
				reverse_o <= rev || |(assigned(fsel_r, FN_JOG_REV) & din_r);
			terminal_config_error_o <= (main_fsrc_r == FSRC_UPDOWN) && (ud_only_one || (up && dn));
			output_block_message_o <= first_num(assigned(fsel_r, FN_BLOCK) & din_r);
		end
	end
endmodule

// *** shared/dif_pkg.sv ***
// Constants shared by the digital input function logic
package dif_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int FW = 16;
	localparam int CODE_W = 6;
	localparam int NTERM = 8;
	localparam int SRC_W = 3;
	// Clock and slow tick
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int JOG_LIMIT_MS = 500;
	localparam logic [9:0] JOG_LIMIT_TICKS = 10'(JOG_LIMIT_MS * 1000000 / TICK_PERIOD_NS);
	// Register indexes
	localparam logic [7:0] REG_FSEL_BASE = 8'h00;
	localparam logic [7:0] REG_MAIN_FSRC = 8'h08;
	localparam logic [7:0] REG_UPPER = 8'h09;
	localparam logic [7:0] REG_LOWER = 8'h0a;
	localparam logic [7:0] REG_JOG_FREQ = 8'h0b;
	localparam logic [7:0] REG_ACC1 = 8'h0c;
	localparam logic [7:0] REG_DEC1 = 8'h0d;
	localparam logic [7:0] REG_ACC2 = 8'h0e;
	localparam logic [7:0] REG_DEC2 = 8'h0f;
	localparam logic [7:0] REG_ESTOP_DEC = 8'h10;
	localparam logic [7:0] REG_CTRL = 8'h11;
	localparam logic [7:0] REG_MAIN_RSRC = 8'h12;
	localparam logic [7:0] REG_ALT_RSRC = 8'h13;
	localparam logic [7:0] REG_ALT_FSRC = 8'h14;
	localparam logic [7:0] REG_FREQ_REF = 8'h15;
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam logic [7:0] REG_OUT_FREQ = 8'h21;
	localparam logic [7:0] REG_MSG = 8'h22;
	localparam logic [7:0] REG_HELD = 8'h23;
	// Control register fields
	localparam int CTRL_COAST = 0;
	localparam int CTRL_RETAIN = 1;
	localparam int CTRL_PID = 2;
	localparam int CTRL_SSRCH = 3;
	localparam int CTRL_SET2 = 4;
	// Reset values
	localparam logic [CODE_W-1:0] FSEL_RST = 6'h3f;
	localparam logic [FW-1:0] UPPER_RST = 16'h1770;
	localparam logic [FW-1:0] LOWER_RST = 16'h0000;
	localparam logic [FW-1:0] JOG_RST = 16'h0258;
	localparam logic [FW-1:0] TIME_RST = 16'h000a;
	localparam logic [SRC_W-1:0] SRC_RST = 3'h1;
	// Source codes reported on the source outputs
	localparam logic [SRC_W-1:0] SRC_LOCAL = 3'h0;
	localparam logic [SRC_W-1:0] SRC_PID = 3'h7;
	localparam logic [SRC_W-1:0] FSRC_UPDOWN = 3'h2;
	// Input function codes
	localparam logic [CODE_W-1:0] FN_FWD = 6'h00;
	localparam logic [CODE_W-1:0] FN_REV = 6'h01;
	localparam logic [CODE_W-1:0] FN_JOG_FWD = 6'h06;
	localparam logic [CODE_W-1:0] FN_JOG_REV = 6'h07;
	localparam logic [CODE_W-1:0] FN_UP = 6'h08;
	localparam logic [CODE_W-1:0] FN_DOWN = 6'h09;
	localparam logic [CODE_W-1:0] FN_HOLD = 6'h0b;
	localparam logic [CODE_W-1:0] FN_RUN_ALT = 6'h0c;
	localparam logic [CODE_W-1:0] FN_FREQ_ALT = 6'h0d;
	localparam logic [CODE_W-1:0] FN_ESTOP = 6'h0e;
	localparam logic [CODE_W-1:0] FN_BLOCK = 6'h0f;
	localparam logic [CODE_W-1:0] FN_FRESET = 6'h11;
	localparam logic [CODE_W-1:0] FN_EXT_FAULT = 6'h19;
	localparam logic [CODE_W-1:0] FN_WIRE3 = 6'h1a;
	localparam logic [CODE_W-1:0] FN_LOC_REM = 6'h1b;
	localparam logic [CODE_W-1:0] FN_ACC_SET2 = 6'h1e;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RUN = 4'b0010,
		ST_DECEL = 4'b0100,
		ST_LOCKED = 4'b1000
	} dif_state_t;
endpackage

// *** design/dif_ramp.sv ***
// Frequency ramp: one unit step per elapsed ramp period
module dif_ramp (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic load_i,
	input wire logic [dif_pkg::FW-1:0] load_val_i,
	input wire logic [dif_pkg::FW-1:0] target_i,
	input wire logic [dif_pkg::FW-1:0] acc_per_i,
	input wire logic [dif_pkg::FW-1:0] dec_per_i,
	// Result
	output logic [dif_pkg::FW-1:0] freq_o
);
	import dif_pkg::*;
	logic [FW-1:0] cnt_r;
	logic [FW-1:0] per;

	assign per = (target_i > freq_o) ? acc_per_i : dec_per_i;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
			freq_o <= '0;
		end else if (load_i) begin
			cnt_r <= '0;
			freq_o <= load_val_i;
		end else if (!run_i || target_i == freq_o) begin
			// Paused ramp keeps its partial period
			if (target_i == freq_o)
				cnt_r <= '0;
		end else if (tick_i) begin
			if (cnt_r >= per) begin
				cnt_r <= '0;
				if (target_i > freq_o)
					freq_o <= freq_o + 16'h0001;
				else
					freq_o <= freq_o - 16'h0001;
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end
endmodule

// *** test/dif_props.sv ***
// Assertion checker for the digital input command logic
module dif_props
	import dif_pkg::*;
#(
	parameter int TICK_CYC = 4
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic [FW-1:0] freq_o,
	input wire logic out_en_o,
	input wire logic [SRC_W-1:0] freq_src_o,
	input wire logic trip_o,
	input wire logic [3:0] output_block_message_o,
	input wire logic [3:0] external_fault_message_o,
	input wire logic nv_store_o
);
	logic pid_r;
	// Shadow of the PID enable bit, taken from bus writes
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pid_r <= 1'b0;
		end else if (wr_i && addr_i == REG_CTRL) begin
			pid_r <= wdata_i[CTRL_PID];
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	property p_blk_range;
		output_block_message_o <= 4'h8;
	endproperty
	a_blk_range: assert property (p_blk_range) else $error("block message out of range");
	property p_blk_off;
		output_block_message_o != 4'h0 && $past(output_block_message_o) != 4'h0 |-> !out_en_o && freq_o == 16'h0000;
	endproperty
	a_blk_off: assert property (p_blk_off) else $error("output live during block");
	property p_xf_range;
		external_fault_message_o <= 4'h8;
	endproperty
	a_xf_range: assert property (p_xf_range) else $error("fault message out of range");
	property p_xf_trip;
		$rose(external_fault_message_o != 4'h0) |-> ##[0:1] trip_o;
	endproperty
	a_xf_trip: assert property (p_xf_trip) else $error("fault message without trip");
	property p_trip_off;
		$rose(trip_o) |-> ##[0:2] !out_en_o;
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("output not off on trip");
	property p_nv_pulse;
		nv_store_o |=> !nv_store_o;
	endproperty
	a_nv_pulse: assert property (p_nv_pulse) else $error("store pulse too long");
	property p_ramp;
		out_en_o && $past(out_en_o) && $past(out_en_o, 2) |->
			freq_o == $past(freq_o) || freq_o == $past(freq_o) + 16'h0001 || freq_o == $past(freq_o) - 16'h0001;
	endproperty
	a_ramp: assert property (p_ramp) else $error("frequency jumped while running");
	property p_pid;
		$rose(pid_r) |-> ##[1:4] (freq_src_o == SRC_PID || freq_src_o == SRC_LOCAL);
	endproperty
	a_pid: assert property (p_pid) else $error("PID source not taken");
endmodule

bind dif_top dif_props #(.TICK_CYC(TICK_CYC)) u_props (.ref_clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .freq_o,
	.out_en_o, .freq_src_o, .trip_o, .output_block_message_o, .external_fault_message_o, .nv_store_o);

// *** test/dif_switches.sv ***
// Switch bank model driving the input terminals
module dif_switches #(
	parameter int RUN_T = 0,
	parameter int RST_T = 7
) (
	input wire logic clk_i,
	input wire logic [7:0] want_i,
	input wire logic strict_i,
	input wire logic [3:0] lag_i,
	output logic [7:0] term_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tgt_r = 8'h00;
	logic [3:0] cnt_r = 4'h0;
	logic [7:0] run_m;
	assign run_m = 8'h01 << RUN_T;
	initial term_o = 8'h00;
	// Lag stands for slow relays; each change restarts it
	always @(posedge clk_i) begin
		if (want_i != tgt_r) begin
			tgt_r <= want_i;
			cnt_r <= lag_i;
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end else if (strict_i && tgt_r[RST_T]) begin
			term_o <= term_o[RUN_T] ? (term_o & ~run_m) : (tgt_r & ~run_m);
		end else begin
			term_o <= tgt_r;
		end
	end
endmodule

// *** test/tb.sv ***
// Testbench for the digital input command logic
module tb;
	import dif_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, strict = 1'b0;
	logic [7:0] addr = 8'h00, want = 8'h00, term;
	logic [15:0] wdata = 16'h0000, rdata, freq, nvd, f0, nv_last;
	logic [3:0] lag = 4'h0, bmsg, xmsg;
	logic [2:0] rsrc, fsrc;
	logic oe, rev, cfg, trip, nvs;
	int bad_count = 0, checks_done = 0, cyc = 0, n, nv_cnt = 0;

	always #20 clk = ~clk;

	dif_top #(.TICK_CYC(4)) dut (.ref_clk_i(clk), .resetn_i(rstn), .term_i(term), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .freq_o(freq), .out_en_o(oe), .reverse_o(rev), .run_src_o(rsrc),
		.freq_src_o(fsrc), .terminal_config_error_o(cfg), .trip_o(trip), .output_block_message_o(bmsg),
		.external_fault_message_o(xmsg), .nv_store_o(nvs), .nv_data_o(nvd));
	dif_switches #(.RUN_T(0), .RST_T(7)) sw (.clk_i(clk), .want_i(want), .strict_i(strict), .lag_i(lag), .term_o(term));

	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Budget covers the 500 ms jog plus ramps, with margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	always @(posedge clk) begin
		if (nvs === 1'b1) begin
			nv_cnt++;
			nv_last = nvd;
		end
	end

	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", rdata, e);
	endtask
	task set_t(input int b, input logic v);
		@(posedge clk);
		want[b] <= v;
	endtask
	task nw(input int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rd_reg(REG_FSEL_BASE, {10'h000, FSEL_RST});
		rd_reg(REG_UPPER, UPPER_RST);
		rd_reg(REG_LOWER, LOWER_RST);
		rd_reg(REG_JOG_FREQ, JOG_RST);
		rd_reg(REG_ACC1, TIME_RST);
		rd_reg(REG_MAIN_RSRC, {13'h0000, SRC_RST});
		rd_reg(8'h30, 16'h0000);
		$display("register test done");
		wr_reg(REG_FREQ_REF, 16'h0064);
		wr_reg(REG_JOG_FREQ, 16'h0014);
		wr_reg(REG_ACC1, 16'h0000);
		wr_reg(REG_DEC1, 16'h0000);
		wr_reg(REG_CTRL, 16'h0001);
		wr_reg(8'h00, {10'h000, FN_FWD});
		wr_reg(8'h01, {10'h000, FN_JOG_FWD});
		set_t(1, 1'b1);
		for (n = 0; n < 100 && oe !== 1'b1; n++) @(negedge clk);
		for (n = 0; n < 3000 && oe === 1'b1; n++) begin
			if (n == 200) chk("jog freq", freq, 16'h0014);
			@(negedge clk);
		end
		chk("jog stop time", 16'(n > 1900 && n < 2100), 16'h0001);
		set_t(1, 1'b0);
		$display("jog test done");
		wr_reg(REG_MAIN_FSRC, 16'h0002);
		wr_reg(REG_UPPER, 16'h001e);
		wr_reg(REG_LOWER, 16'h0005);
		wr_reg(8'h02, {10'h000, FN_UP});
		nw(6);
		chk("cfg one", cfg, 16'h0001);
		wr_reg(8'h03, {10'h000, FN_DOWN});
		nw(6);
		chk("cfg pair", cfg, 16'h0000);
		chk("fsrc", fsrc, FSRC_UPDOWN);
		set_t(0, 1'b1);
		set_t(2, 1'b1);
		repeat (3) @(posedge clk);
		set_t(2, 1'b0);
		nw(200);
		chk("pulse to lower", freq, 16'h0005);
		set_t(2, 1'b1);
		nw(200);
		chk("upper clamp", freq, 16'h001e);
		set_t(3, 1'b1);
		nw(20);
		chk("cfg both", cfg, 16'h0001);
		chk("both holds", freq, 16'h001e);
		set_t(2, 1'b0);
		nw(200);
		chk("lower clamp", freq, 16'h0005);
		set_t(3, 1'b0);
		nw(8);
		f0 = freq;
		nw(40);
		chk("no input holds", freq, 16'h0005);
		$display("up down test done");
		wr_reg(REG_CTRL, 16'h0002);
		wr_reg(8'h04, {10'h000, FN_HOLD});
		set_t(2, 1'b1);
		nw(8);
		set_t(4, 1'b1);
		nw(8);
		f0 = freq;
		nw(40);
		chk("hold freq", freq, f0);
		chk("hold stored", 16'(nv_cnt), 16'h0001);
		set_t(4, 1'b0);
		nw(20);
		chk("store cleared", 16'(nv_cnt), 16'h0002);
		chk("cleared value", nv_last, 16'h0000);
		chk("ramp resumed", 16'(freq > f0), 16'h0001);
		set_t(2, 1'b0);
		$display("hold test done");
		wr_reg(REG_CTRL, 16'h0000);
		wr_reg(REG_MAIN_FSRC, 16'h0001);
		wr_reg(8'h05, {10'h000, FN_BLOCK});
		nw(40);
		lag = 4'h9;
		set_t(5, 1'b1);
		nw(20);
		chk("block msg", bmsg, 16'h0006);
		chk("block off", oe, 16'h0000);
		set_t(5, 1'b0);
		for (n = 0; n < 60 && oe !== 1'b1; n++) @(negedge clk);
		chk("resume from zero", 16'(oe === 1'b1 && freq < 16'h0002), 16'h0001);
		wr_reg(REG_CTRL, 16'h0008);
		set_t(5, 1'b1);
		nw(20);
		set_t(5, 1'b0);
		nw(20);
		chk("resume from ref", freq, 16'h0064);
		$display("block test done");
		lag = 4'h0;
		wr_reg(8'h06, {10'h000, FN_EXT_FAULT});
		wr_reg(8'h07, {10'h000, FN_FRESET});
		set_t(6, 1'b1);
		nw(8);
		chk("fault trip", trip, 16'h0001);
		chk("fault msg", xmsg, 16'h0007);
		chk("fault off", oe, 16'h0000);
		set_t(6, 1'b0);
		set_t(7, 1'b1);
		nw(8);
		chk("reset with run", trip, 16'h0001);
		set_t(7, 1'b0);
		nw(4);
		strict = 1'b1;
		set_t(7, 1'b1);
		nw(12);
		chk("reset accepted", trip, 16'h0000);
		set_t(7, 1'b0);
		$display("fault test done");
		wr_reg(REG_ALT_RSRC, 16'h0003);
		wr_reg(REG_ALT_FSRC, 16'h0004);
		wr_reg(8'h04, {10'h000, FN_RUN_ALT});
		wr_reg(8'h06, {10'h000, FN_FREQ_ALT});
		wr_reg(REG_CTRL, 16'h0004);
		set_t(4, 1'b1);
		set_t(6, 1'b1);
		nw(6);
		chk("pid source", fsrc, SRC_PID);
		chk("alt run source", rsrc, 16'h0003);
		wr_reg(REG_CTRL, 16'h0000);
		nw(4);
		chk("alt freq source", fsrc, 16'h0004);
		wr_reg(8'h02, {10'h000, FN_LOC_REM});
		set_t(2, 1'b1);
		nw(6);
		chk("local sources", {rsrc, fsrc}, {10'h000, SRC_LOCAL, SRC_LOCAL});
		set_t(2, 1'b0);
		$display("source test done");
		wr_reg(8'h01, 16'h003f);
		set_t(3, 1'b1);
		wr_reg(8'h03, {10'h000, FN_WIRE3});
		for (n = 0; n < 900 && oe !== 1'b0; n++) @(negedge clk);
		chk("3-wire stop", 16'(n < 900), 16'h0001);
		set_t(1, 1'b1);
		nw(8);
		chk("3-wire reverse run", {rev, oe}, 16'h0003);
		$display("3-wire test done");
		finish_test();
	end
endmodule
